//--- core/overcurrent_gate.sv
// over-current reporting gate, global or per port
`timescale 1ns/1ps
`default_nettype none
module overcurrent_gate
  import rh_desc_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic                     report_enable, // reporting on
  input  wire logic                     per_port,      // per-port mode
  input  wire logic                     oc_global_in,  // shared sense
  input  wire logic [NUM_PORT_PINS-1:0] oc_port_in,    // per-port sense
  output var  logic [NUM_PORT_PINS-1:0] overcurrent_flag
);
  // one flop per port; the mode bit only matters while reporting
  genvar g;
  generate
    for (g = 0; g < NUM_PORT_PINS; g++)
    begin : port_flag
      wire next_flag = report_enable &
                       (per_port ? oc_port_in[g] : oc_global_in);
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
          overcurrent_flag[g] <= 1'b0;
        else
          overcurrent_flag[g] <= next_flag;
      end
    end
  endgenerate
endmodule : overcurrent_gate
`default_nettype wire

//--- core/power_good_timer.sv
// port power-on to power-good delay sequencer
`timescale 1ns/1ps
`default_nettype none
module power_good_timer
  import rh_desc_pkg::*;
#(
  parameter int UNIT_CYCLES = PGD_UNIT_CYC
)(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             power_on,    // port power switched on
  input  wire logic [PGD_W-1:0] delay,       // delay in 2 ms units
  output var  logic             power_good   // power now counted valid
);
  pg_state_type     state;        // sequencer state
  pg_state_type     next_state;   // its next value
  logic [PGD_W-1:0] units;        // units still to wait
  logic [31:0]      cnt;          // cycles inside the current unit
  logic [31:0]      elapsed;      // helper: wait cycles so far
  logic [PGD_W-1:0] latched;      // helper: delay taken at start
  wire              unit_done = (cnt == 32'(UNIT_CYCLES - 1));
  wire              last_unit = (units == PGD_W'(1));

  // next state: a zero delay counts as good at once
  always_comb
  begin
    next_state = state;
    case (state)
      PG_OFF:  if (power_on) next_state = (delay == '0) ? PG_GOOD : PG_WAIT;
      PG_WAIT:
      begin
        if (!power_on)
          next_state = PG_OFF;
        else if (unit_done && last_unit)
          next_state = PG_GOOD;
      end
      PG_GOOD: if (!power_on) next_state = PG_OFF;
      default: next_state = PG_OFF;
    endcase
  end

  // state, unit and cycle counters
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state      <= PG_OFF;
      units      <= '0;
      cnt        <= '0;
      power_good <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      power_good <= (next_state == PG_GOOD);
      if (state != PG_WAIT)
      begin
        units <= delay;   // delay sampled as power goes on
        cnt   <= '0;
      end
      else if (unit_done)
      begin
        units <= units - PGD_W'(1); // one 2 ms unit gone
        cnt   <= '0;
      end
      else
        cnt <= cnt + 32'd1;
    end
  end

  // helper counting for the delay check
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      elapsed <= '0;
      latched <= '0;
    end
    else if (state == PG_WAIT)
      elapsed <= elapsed + 32'd1;
    else
    begin
      elapsed <= '0;
      latched <= delay;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_good_after_units: assert property (
    $rose(power_good) && $past(state) == PG_WAIT |-> elapsed == 32'(latched) * 32'(UNIT_CYCLES))
    else $error("power good came before the programmed delay");
  c_power_good: cover property ($rose(power_good) && $past(state) == PG_WAIT);
endmodule : power_good_timer
`default_nettype wire

//--- core/root_hub_descriptor_a.sv
// root hub descriptor a register with its power and over-current outputs
// Notes on behaviour
// - power-good delay counts 2 ms units
// - only low two delay bits stored
// - absent-protection bit suppresses over-current reporting
// - over-current granularity only while reporting
// - always-powered bit keeps ports powered
// - switch granularity only while switching used
// - port count in low byte, reset image
`timescale 1ns/1ps
`default_nettype none
module root_hub_descriptor_a
  import rh_desc_pkg::*;
#(
  parameter int PGD_UNIT_CYCLES = PGD_UNIT_CYC  // cycles per 2 ms unit
)(
  input  wire logic                     clk,
  input  wire logic                     reset,
  // register port
  input  wire logic [31:0]              addr,
  input  wire logic [31:0]              wdata,
  input  wire logic                     write_strobe,
  input  wire logic                     read_strobe,
  output var  logic [31:0]              rdata,
  // power switching side
  input  wire logic                     port_power_request,
  output var  logic                     port_power_enable,
  output var  logic                     power_good,
  output var  logic                     power_switch_absent,
  output var  logic                     power_switch_granularity,
  // over-current side
  input  wire logic                     oc_global_in,
  input  wire logic [NUM_PORT_PINS-1:0] oc_port_in,
  output var  logic                     overcurrent_report_enable,
  output var  logic                     overcurrent_granularity,
  output var  logic [NUM_PORT_PINS-1:0] overcurrent_flag,
  // plain copies of the stored fields
  output var  logic [PGD_W-1:0]         power_good_delay,
  output var  logic [PORTS_W-1:0]       downstream_port_count
);

  // stored fields; power_good_delay and downstream_port_count are
  // the output flops themselves
  logic             overcurrent_protection_absent; // no reporting
  logic             ocg_field;                     // raw granularity
  logic             ports_always_powered;          // raw power bit
  logic             psg_field;                     // raw switch granularity

  // limitations a user of this block should know:
  // the mode outputs trail the field flops by one cycle, so logic
  // reacting to a write still sees the old mode for that cycle
  // the sequencer and the flag gate take the unregistered mode, so
  // they do not add that cycle on top of their own delay
  // a delay of zero counts as good at once; software is told not to
  // use it, and it is not refused here
  // the port count is plain storage and is never compared against
  // the number of over-current pins wired in
  // read data drop to zero after one cycle, so nothing stale lingers

  // decode helper, used for both strobes
  function automatic logic addr_hit(input logic [31:0] a);
    addr_hit = (a == RHDA_ADDR);
  endfunction : addr_hit

  wire              write_hit = write_strobe & addr_hit(addr); // write decode
  wire              read_hit  = read_strobe & addr_hit(addr);  // read decode

  // read image; anything not stored is a constant zero
  logic [31:0]      image;
  always_comb
  begin
    image                           = '0;
    image[PGD_LSB +: PGD_W]         = power_good_delay;
    image[OCP_ABS_BIT]              = overcurrent_protection_absent;
    image[OCG_BIT]                  = ocg_field;
    image[PWR_ABS_BIT]              = ports_always_powered;
    image[PSG_BIT]                  = psg_field;
    image[PORTS_LSB +: PORTS_W]     = downstream_port_count;
  end

  // unmapped reads return zero so software never sees stale data
  wire [31:0]       next_rdata = read_hit ? image : 32'h0000_0000;

  // effective mode outputs; each mode bit is forced to the global
  // choice while the feature it qualifies is off
  wire              next_oc_report = ~overcurrent_protection_absent;
  wire              next_oc_gran   = next_oc_report & ocg_field;
  wire              next_pwr_en    = port_power_request |
                                     ports_always_powered;
  wire              next_ps_gran   = ~ports_always_powered & psg_field;

  // delay field; the upper delay bits are dropped on write
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      power_good_delay <= PGD_RESET;
    else if (write_hit)
      power_good_delay <= wdata[PGD_LSB +: PGD_W];
  end

  // port count; plain storage, nothing here depends on it
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      downstream_port_count <= PORTS_RESET;
    else if (write_hit)
      downstream_port_count <= wdata[PORTS_LSB +: PORTS_W];
  end

  // mode bits; reserved and device-type bits are not stored
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      overcurrent_protection_absent <= OCP_ABS_RESET;
      ocg_field                     <= OCG_RESET;
      ports_always_powered          <= PWR_ABS_RESET;
      psg_field                     <= PSG_RESET;
    end
    else if (write_hit)
    begin
      overcurrent_protection_absent <= wdata[OCP_ABS_BIT];
      ocg_field                     <= wdata[OCG_BIT];
      ports_always_powered          <= wdata[PWR_ABS_BIT];
      psg_field                     <= wdata[PSG_BIT];
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rdata <= '0;
    else
      rdata <= next_rdata;
  end

  // registered mode outputs, one cycle behind the fields
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      overcurrent_report_enable <= 1'b0;
      overcurrent_granularity   <= 1'b0;
      port_power_enable         <= 1'b0;
      power_switch_absent       <= 1'b0;
      power_switch_granularity  <= 1'b0;
    end
    else
    begin
      overcurrent_report_enable <= next_oc_report;
      overcurrent_granularity   <= next_oc_gran;
      port_power_enable         <= next_pwr_en;
      power_switch_absent       <= ports_always_powered;
      power_switch_granularity  <= next_ps_gran;
    end
  end

  // power-good sequencer follows the effective port power
  power_good_timer #(
    .UNIT_CYCLES (PGD_UNIT_CYCLES)
  ) u_timer (
    .clk        (clk),
    .reset      (reset),
    .power_on   (next_pwr_en),
    .delay      (power_good_delay),
    .power_good (power_good)
  );

  // over-current flags, gated by the reporting options
  overcurrent_gate u_oc (
    .clk              (clk),
    .reset            (reset),
    .report_enable    (next_oc_report),
    .per_port         (ocg_field),
    .oc_global_in     (oc_global_in),
    .oc_port_in       (oc_port_in),
    .overcurrent_flag (overcurrent_flag)
  );

  // checks on the register and the mode outputs
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_pgd_upper_zero: assert property (
    read_hit |=> rdata[31:PGD_LSB + PGD_W] == '0)
    else $error("upper delay bits read non-zero");

  a_pgd_write_kept: assert property (
    write_hit |=> power_good_delay == $past(wdata[PGD_LSB +: PGD_W]))
    else $error("delay field did not take the written low bits");

  a_reserved_read_zero: assert property (
    read_hit |=> rdata[PGD_LSB-1:OCP_ABS_BIT+1] == '0 && !rdata[DEV_TYPE_BIT])
    else $error("reserved or device-type bit read non-zero");

  a_port_count_read: assert property (
    read_hit && !write_hit |=> rdata[PORTS_LSB +: PORTS_W] == $past(downstream_port_count))
    else $error("port count not returned in low byte");

  a_unmapped_read_zero: assert property (
    read_strobe && !read_hit |=> rdata == '0)
    else $error("unmapped read returned data");

  a_oc_not_reported: assert property (
    overcurrent_protection_absent |=> overcurrent_flag == '0 && !overcurrent_report_enable)
    else $error("over-current reported while protection absent");

  a_oc_global_mode: assert property (
    !overcurrent_protection_absent && !ocg_field && oc_global_in |=> &overcurrent_flag)
    else $error("global over-current not spread to all ports");

  a_always_powered: assert property (
    ports_always_powered |=> port_power_enable)
    else $error("ports not powered with always-powered set");

  a_switched_power: assert property (
    !ports_always_powered && !port_power_request |=> !port_power_enable)
    else $error("port power on without request in switched mode");

  a_psg_ignored: assert property (
    ports_always_powered ##1 ports_always_powered |-> !power_switch_granularity)
    else $error("switch granularity honoured without switching");

  a_oc_gran_ignored: assert property (
    overcurrent_protection_absent |=> !overcurrent_granularity)
    else $error("over-current granularity honoured without reporting");

  // field storage: each field takes its write bits and holds otherwise,
  // so a write to another address can never leak into the register
  a_port_count_write: assert property (
    write_hit |=> downstream_port_count == $past(wdata[PORTS_LSB +: PORTS_W]))
    else $error("port count did not take the written byte");

  a_absent_bit_write: assert property (
    write_hit |=> overcurrent_protection_absent == $past(wdata[OCP_ABS_BIT]))
    else $error("protection-absent bit did not take the written value");

  a_ocg_bit_write: assert property (
    write_hit |=> ocg_field == $past(wdata[OCG_BIT]))
    else $error("over-current granularity bit did not take the written value");

  a_powered_bit_write: assert property (
    write_hit |=> ports_always_powered == $past(wdata[PWR_ABS_BIT]))
    else $error("always-powered bit did not take the written value");

  a_psg_bit_write: assert property (
    write_hit |=> psg_field == $past(wdata[PSG_BIT]))
    else $error("switch granularity bit did not take the written value");

  a_fields_hold: assert property (
    !write_hit |=> $stable(power_good_delay) && $stable(downstream_port_count))
    else $error("delay or port count changed without a write");

  a_mode_bits_hold: assert property (
    !write_hit |=> $stable(overcurrent_protection_absent) && $stable(ports_always_powered) &&
                  $stable(ocg_field) && $stable(psg_field))
    else $error("mode bit changed without a write");

  // read path: data only in the cycle after a hit, zero otherwise
  a_read_image_whole: assert property (
    read_hit |=> rdata == $past(image))
    else $error("read data differ from the register image");

  a_rdata_idle_zero: assert property (
    !read_strobe |=> rdata == '0)
    else $error("read data seen without a read strobe");

  // mode outputs: the qualifying bit lets the granularity through
  a_ocg_honoured: assert property (
    !overcurrent_protection_absent && ocg_field |=> overcurrent_granularity)
    else $error("over-current granularity not honoured while reporting");

  a_oc_per_port: assert property (
    !overcurrent_protection_absent && ocg_field |=> overcurrent_flag == $past(oc_port_in))
    else $error("per-port over-current flags do not follow the port senses");

  a_psg_honoured: assert property (
    !ports_always_powered && psg_field |=> power_switch_granularity)
    else $error("switch granularity not honoured while switching");

  a_absent_copy: assert property (
    ports_always_powered |=> power_switch_absent)
    else $error("switch-absent output not set with always-powered bit");

  a_request_powers: assert property (
    port_power_request |=> port_power_enable)
    else $error("requested port power not enabled");

  a_good_needs_power: assert property (
    !next_pwr_en |=> !power_good)
    else $error("power good shown without port power");

  c_write_hit:    cover property (write_hit);
  c_read_hit:     cover property (read_hit ##1 rdata != '0);
  c_per_port_oc:  cover property (overcurrent_granularity && overcurrent_flag != '0);
  c_individual:   cover property (power_switch_granularity);

endmodule : root_hub_descriptor_a
`default_nettype wire

//--- pkg/rh_desc_pkg.sv
// constants for the root hub descriptor a register block
package rh_desc_pkg;
  // register location and reset image
  localparam logic [31:0] RHDA_ADDR     = 32'hB000_7048;
  localparam logic [31:0] RHDA_RESET    = 32'h0100_0002;
  // field positions
  localparam int          PGD_LSB       = 24;
  localparam int          PGD_W         = 2;
  localparam int          OCP_ABS_BIT   = 12;
  localparam int          OCG_BIT       = 11;
  localparam int          DEV_TYPE_BIT  = 10;
  localparam int          PWR_ABS_BIT   = 9;
  localparam int          PSG_BIT       = 8;
  localparam int          PORTS_LSB     = 0;
  localparam int          PORTS_W       = 8;
  // reset values of the fields, taken from the reset image
  localparam logic [1:0]  PGD_RESET     = RHDA_RESET[PGD_LSB +: PGD_W];
  localparam logic [7:0]  PORTS_RESET   = RHDA_RESET[PORTS_LSB +: PORTS_W];
  localparam logic        OCP_ABS_RESET = RHDA_RESET[OCP_ABS_BIT];
  localparam logic        OCG_RESET     = RHDA_RESET[OCG_BIT];
  localparam logic        PWR_ABS_RESET = RHDA_RESET[PWR_ABS_BIT];
  localparam logic        PSG_RESET     = RHDA_RESET[PSG_BIT];
  // power-good unit time and its cycle count at the system clock
  localparam int          PGD_UNIT_MS   = 2;
  localparam int          CLK_HZ        = 25_000_000;
  localparam int          PGD_UNIT_CYC  = PGD_UNIT_MS * (CLK_HZ / 1000);
  // number of over-current input pins wired to this block
  localparam int          NUM_PORT_PINS = 2;
  // power-good sequencer states
  typedef enum logic [1:0] {PG_OFF, PG_WAIT, PG_GOOD} pg_state_type;
endpackage : rh_desc_pkg

//--- test/usb_root_hub_descriptor_a_bench.sv
// self-checking bench for the root hub descriptor a register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module usb_root_hub_descriptor_a_bench;
  import rh_desc_pkg::*;
  localparam int          U       = 4;             // short power-good unit keeps the run brief
  localparam logic [31:0] RW_MASK = 32'h0300_1BFF; // bits that store and read back
  logic                     clk;
  logic                     reset;
  logic [31:0]              addr;
  logic [31:0]              wdata;
  logic                     write_strobe;
  logic                     read_strobe;
  logic [31:0]              rdata;
  logic                     port_power_request;
  logic                     port_power_enable;
  logic                     power_good;
  logic                     power_switch_absent;
  logic                     power_switch_granularity;
  logic                     oc_global_in;
  logic [NUM_PORT_PINS-1:0] oc_port_in;
  logic                     overcurrent_report_enable;
  logic                     overcurrent_granularity;
  logic [NUM_PORT_PINS-1:0] overcurrent_flag;
  logic [PGD_W-1:0]         power_good_delay;
  logic [PORTS_W-1:0]       downstream_port_count;
  int                       failures;  // mismatches seen
  int                       cmp_count; // comparisons made

  root_hub_descriptor_a #(.PGD_UNIT_CYCLES(U)) dut (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .rdata(rdata),
    .port_power_request(port_power_request), .port_power_enable(port_power_enable),
    .power_good(power_good), .power_switch_absent(power_switch_absent),
    .power_switch_granularity(power_switch_granularity), .oc_global_in(oc_global_in),
    .oc_port_in(oc_port_in), .overcurrent_report_enable(overcurrent_report_enable),
    .overcurrent_granularity(overcurrent_granularity), .overcurrent_flag(overcurrent_flag),
    .power_good_delay(power_good_delay), .downstream_port_count(downstream_port_count)
  );

  // free-running system clock
  always #20 clk = ~clk;

  // one-cycle write; strobe drops at the taking edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    write_strobe <= 1'b1;
    addr         <= a;
    wdata        <= d;
    @(posedge clk);
    write_strobe <= 1'b0;
  endtask : wr

  // one-cycle read; data looked at only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    read_strobe <= 1'b1;
    addr        <= a;
    @(posedge clk);
    read_strobe <= 1'b0;
    #1;
    `CHK("rdata", exp, rdata)
  endtask : rd

  // let derived mode outputs catch up with the field flops
  task automatic settle();
    @(posedge clk);
    #1;
  endtask : settle

  // reset image and its field copies
  task automatic test_reset();
    rd(RHDA_ADDR, 32'h0100_0002);
    `CHK("ports", 8'h02, downstream_port_count)
    `CHK("pgd", 2'h1, power_good_delay)
    `CHK("oc enable", 1'b1, overcurrent_report_enable)
    $display("test reset done");
  endtask : test_reset

  // stored, reserved and unmapped bits
  task automatic test_masks();
    wr(RHDA_ADDR, 32'hFFFF_FFFF);
    rd(RHDA_ADDR, RW_MASK);
    settle();
    `CHK("oc enable", 1'b0, overcurrent_report_enable)
    `CHK("oc gran", 1'b0, overcurrent_granularity)
    `CHK("sw absent", 1'b1, power_switch_absent)
    `CHK("pwr enable", 1'b1, port_power_enable)
    `CHK("sw gran", 1'b0, power_switch_granularity)
    `CHK("ports", 8'hFF, downstream_port_count)
    wr(RHDA_ADDR, ~RW_MASK);
    rd(RHDA_ADDR, 32'h0000_0000);
    // unmapped neighbour must neither store nor answer
    wr(RHDA_ADDR + 32'h0000_0004, 32'hFFFF_FFFF);
    rd(RHDA_ADDR, 32'h0000_0000);
    rd(RHDA_ADDR + 32'h0000_0004, 32'h0000_0000);
    wr(RHDA_ADDR, 32'h0000_0102);
    settle();
    `CHK("sw gran", 1'b1, power_switch_granularity)
    `CHK("pwr enable", 1'b0, port_power_enable)
    $display("test masks done");
  endtask : test_masks

  // over-current reporting in every mode with two sense patterns
  task automatic test_overcurrent();
    logic [31:0]              img [3];
    logic [NUM_PORT_PINS-1:0] exp;
    logic                     en;
    logic                     gran;
    img = '{32'h0000_0002, 32'h0000_0802, 32'h0000_1802};
    for (int m = 0; m < 3; m++)
    begin
      wr(RHDA_ADDR, img[m]);
      en   = ~img[m][OCP_ABS_BIT];
      gran = en & img[m][OCG_BIT];
      for (int s = 0; s < 2; s++)
      begin
        @(posedge clk);
        oc_global_in <= (s == 0);
        oc_port_in   <= (s == 0) ? 2'b01 : 2'b10;
        repeat (2) @(posedge clk);
        #1;
        // flags follow the sense chosen by the mode, or stay clear
        exp = !en ? 2'b00 : (gran ? ((s == 0) ? 2'b01 : 2'b10) : {2{s == 0}});
        `CHK("oc flag", exp, overcurrent_flag)
        `CHK("oc gran", gran, overcurrent_granularity)
      end
    end
    $display("test overcurrent done");
  endtask : test_overcurrent

  // power-good delay for every non-zero setting, then always-powered
  task automatic test_power();
    int n;
    for (int d = 1; d < 4; d++)
    begin
      wr(RHDA_ADDR, {6'h00, d[1:0], 24'h00_0002});
      repeat (2) @(posedge clk);
      port_power_request <= 1'b1;
      n = 0;
      // bounded wait, counted from the edge that launched the request
      do
      begin
        @(posedge clk);
        #1;
        n++;
      end while (power_good !== 1'b1 && n < 100);
      `CHK("pg cycles", d * U + 1, n)
      `CHK("pwr enable", 1'b1, port_power_enable)
      @(posedge clk);
      port_power_request <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      `CHK("pg drop", 1'b0, power_good)
    end
    wr(RHDA_ADDR, 32'h0100_0202);
    repeat (U + 4) @(posedge clk);
    #1;
    `CHK("pg always", 1'b1, power_good)
    `CHK("pwr enable", 1'b1, port_power_enable)
    $display("test power done");
  endtask : test_power

  // counts, verdict and end of run
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  // main sequence
  initial
  begin
    clk                = 1'b0;
    reset              = 1'b1;
    addr               = 32'h0000_0000;
    wdata              = 32'h0000_0000;
    write_strobe       = 1'b0;
    read_strobe        = 1'b0;
    port_power_request = 1'b0;
    oc_global_in       = 1'b0;
    oc_port_in         = 2'b00;
    failures           = 0;
    cmp_count          = 0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    test_reset();
    test_masks();
    test_overcurrent();
    test_power();
    close_out();
  end

  // watchdog well beyond the hundred or so cycles the tests need
  initial
  begin
    #(40 * 3000);
    failures++;
    close_out();
  end
endmodule : usb_root_hub_descriptor_a_bench
`default_nettype wire
